// File: rtl/vme_trigger_interface_regs.sv
// trigger interface register bank, short-address bus slave and interrupter
// Functional notes
// - short address, 16-bit data, both modifiers
// - base address from bits 15..4 versus switches
// - interrupter levels 1-7, byte ID, release on ack
// - control bit 0 selects external or upstream source
// - control bit 1 gates trigger acceptance
// - control bit 2 lets triggers interrupt
// - test interrupt needs test and enable bits
// - auto sample inputs on upstream trigger
// - reset bit pulse clears controls and trigger latch, not the input port latch
// - level readback, zeros and reserved bits
// - pending bit until acknowledge cycle
// - status bit while trigger data valid
// - byte identifier register, upper bits ones
// - upstream layout sync, late fail, code
// - external layout triggers and data levels
// - bit 12 shows mode, bit 13 one
// - acknowledge write in upstream mode drives cable ack line
// - external acknowledge clears busy and latch
// - output port register, upper bits ones
// - input port latch on read, ones external
// - jumpers gate triggers into OR
// - ack on one line chosen by number
// - rising OR latches all twelve inputs
// - accept outputs held until acknowledge
// - busy while processing a trigger
`timescale 1ns/1ps
`default_nettype none
module vme_trigger_interface_regs
  import trig_if_pkg::*;
#(
  parameter int ACK_LINES = 8
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [trig_if_pkg::ADDR_W-1:0] busAddr,
  input  wire logic [5:0]                  busAm,
  input  wire logic                        busStrobe,
  input  wire logic                        busWrite,
  input  wire logic [trig_if_pkg::DATA_W-1:0] busWdata,
  output logic      [trig_if_pkg::DATA_W-1:0] busRdata,
  output logic                             busDtack,
  input  wire logic                        iackCycle,
  input  wire logic [2:0]                  iackLevel,
  output logic                             irqReq,
  output logic      [2:0]                  irqLevel,
  input  wire logic [trig_if_pkg::BASE_W-1:0] baseSwitch,
  input  wire logic [2:0]                  levelSwitch,
  input  wire logic [2:0]                  readoutNumber,
  input  wire logic [3:0]                  trigEnableJumper,
  input  wire logic [3:0]                  extTrigger,
  input  wire logic [7:0]                  extData,
  input  wire logic                        cableStrobe,
  input  wire logic [7:0]                  cableWord,
  output logic      [ACK_LINES-1:0]        cableAck,
  output logic      [7:0]                  generalOut,
  output logic                             levelAccept,
  output logic                             busy
);
  import trig_if_pkg::*;

  logic [4:0]  ctrl_reg;
  logic [7:0]  irqId_reg;
  logic [7:0]  outPort_reg;
  logic [11:0] trigData_reg;
  logic [11:0] inPort_reg;
  logic        trigValid_reg;
  logic        pending_reg;
  logic        ackOut_reg;
  logic        orPrev_reg;
  logic        strobePrev_reg;
  logic        dtack_reg;
  logic [15:0] rdata_reg;

  // address decode and access qualifiers
  wire        amOk     = (busAm == AM_SHORT_SUP) || (busAm == AM_SHORT_USR);
  wire        boardSel = busAddr[ADDR_W-1:BASE_LSB] == baseSwitch;
  wire [3:0]  offset   = busAddr[BASE_LSB-1:0];
  wire        access   = busStrobe && amOk && boardSel && !iackCycle && !dtack_reg;
  wire        wr       = access && busWrite;
  wire        rd       = access && !busWrite;
  wire        wrCsr    = wr && offset == OFF_CSR;
  wire        wrTrig   = wr && offset == OFF_TRIG;
  wire        softRst  = wrCsr && busWdata[CSR_RST];
  wire        extMode  = ctrl_reg[CSR_EXT];
  wire        trigEn   = ctrl_reg[CSR_TEN];
  wire        irqEn    = ctrl_reg[CSR_IEN];
  wire        ackWrite = wrTrig && busWdata[TRG_ACK];
  wire        testIrq  = wrTrig && busWdata[TRG_TESTIRQ] && ctrl_reg[CSR_TEST] && irqEn;

  // trigger OR through jumpers, edge detect of OR and cable strobe
  wire        trigOr   = |(extTrigger & trigEnableJumper);
  wire        orRise   = trigOr && !orPrev_reg;
  wire        stbRise  = cableStrobe && !strobePrev_reg;
  wire        extAccept = trigEn && extMode && orRise && !trigValid_reg;
  wire        tsAccept  = trigEn && !extMode && stbRise && !trigValid_reg;
  wire        accepted  = extAccept || tsAccept;
  wire        iackHit   = iackCycle && busStrobe && pending_reg && iackLevel == levelSwitch;

  // read data words
  wire [15:0] csrWord  = {trigValid_reg, pending_reg, 3'h0, levelSwitch, 1'b0, 2'h0,
                          ctrl_reg};
  wire [15:0] idWord   = {ONES8, irqId_reg};
  wire [11:0] trigLow  = extMode ? trigData_reg : {ONES4, trigData_reg[7:0]};
  wire [15:0] trigWord = {2'h0, 1'b1, extMode, trigLow};
  wire [15:0] outWord  = {ONES8, outPort_reg};
  wire [15:0] inWord   = extMode ? ONES16 : {ONES4, inPort_reg};
  wire [15:0] rdMux    = offset == OFF_CSR   ? csrWord :
                         offset == OFF_IRQID ? idWord :
                         offset == OFF_TRIG  ? trigWord :
                         offset == OFF_OUTP  ? outWord :
                         offset == OFF_INP   ? inWord : ONES16;

  // control register, soft reset clears bits 0..4
  always_ff @(posedge clock) begin
    if (reset || softRst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrCsr) begin
      ctrl_reg <= busWdata[4:0];
    end
  end

  // identifier and output port registers
  always_ff @(posedge clock) begin
    if (reset || softRst) begin
      irqId_reg   <= BYTE_RESET;
      outPort_reg <= BYTE_RESET;
    end else begin
      if (wr && offset == OFF_IRQID) irqId_reg <= busWdata[7:0];
      if (wr && offset == OFF_OUTP) outPort_reg <= busWdata[7:0];
    end
  end

  // trigger capture and busy state
  always_ff @(posedge clock) begin
    if (reset || softRst) begin
      trigValid_reg <= 1'b0;
      trigData_reg  <= WORD12_RESET;
    end else if (accepted) begin
      trigValid_reg <= 1'b1;
      trigData_reg  <= extAccept ? {extData, extTrigger} : {4'h0, cableWord};
    end else if (ackWrite) begin
      trigValid_reg <= 1'b0;
    end
  end

  // input port latch on read or auto sample
  always_ff @(posedge clock) begin
    if (reset) begin
      inPort_reg <= WORD12_RESET;
    end else if (!extMode && ((rd && offset == OFF_INP) || (tsAccept && ctrl_reg[CSR_AUTO]))) begin
      inPort_reg <= {extData, extTrigger};
    end
  end

  // interrupt request: set wins, released by acknowledge cycle
  always_ff @(posedge clock) begin
    if (reset || softRst) begin
      pending_reg <= 1'b0;
    end else if ((accepted && irqEn) || testIrq) begin
      pending_reg <= 1'b1;
    end else if (iackHit) begin
      pending_reg <= 1'b0;
    end
  end

  // acknowledge to cable, one cycle after software ack in upstream mode
  always_ff @(posedge clock) begin
    if (reset) begin
      ackOut_reg <= 1'b0;
    end else begin
      ackOut_reg <= ackWrite && !extMode;
    end
  end

  // edge history and bus answer
  always_ff @(posedge clock) begin
    if (reset) begin
      orPrev_reg     <= 1'b0;
      strobePrev_reg <= 1'b0;
      dtack_reg      <= 1'b0;
      rdata_reg      <= 16'h0000;
    end else begin
      orPrev_reg     <= trigOr;
      strobePrev_reg <= cableStrobe;
      dtack_reg      <= busStrobe && (access || iackHit || dtack_reg);
      if (rd) rdata_reg <= rdMux;
      else if (iackHit) rdata_reg <= {ONES8, irqId_reg};
    end
  end

  // outputs
  assign busRdata    = rdata_reg;
  assign busDtack    = dtack_reg;
  assign irqReq      = pending_reg;
  assign irqLevel    = levelSwitch;
  assign generalOut  = outPort_reg;
  assign cableAck    = ackOut_reg ? (ACK_LINES'(1) << readoutNumber) : '0;
  assign levelAccept = trigValid_reg && extMode;
  assign busy        = trigValid_reg;

  // steps of a bus access, an acknowledge cycle and a trigger
  sequence s_bus_taken;
    access && !softRst;
  endsequence

  sequence s_bus_answered;
    busDtack;
  endsequence

  sequence s_iack_taken;
    iackHit && !testIrq && !accepted;
  endsequence

  sequence s_iack_answered;
    busDtack && !irqReq;
  endsequence

  sequence s_ext_taken;
    extAccept && !softRst && !wrCsr;
  endsequence

  sequence s_ext_held;
    busy && levelAccept;
  endsequence

  sequence s_up_taken;
    tsAccept && !softRst;
  endsequence

  // an access that is taken is answered on the next edge
  a_bus_answer: assert property (@(posedge clock) disable iff (reset)
    s_bus_taken |=> s_bus_answered) else $error("access not answered");

  // the answer stands while the strobe stands
  a_dtack_hold: assert property (@(posedge clock) disable iff (reset)
    busDtack && busStrobe |=> busDtack) else $error("dtack dropped early");

  // the answer goes once the strobe is gone
  a_dtack_drop: assert property (@(posedge clock) disable iff (reset)
    !busStrobe |=> !busDtack) else $error("dtack stuck high");

  // a foreign address modifier gets no answer
  a_bad_modifier: assert property (@(posedge clock) disable iff (reset)
    busStrobe && !amOk && !iackCycle && !busDtack |=> !busDtack) else $error("bad modifier answered");

  // another board's address gets no answer
  a_foreign_base: assert property (@(posedge clock) disable iff (reset)
    busStrobe && !boardSel && !iackCycle && !busDtack |=> !busDtack) else $error("foreign base answered");

  // the acknowledge cycle is answered and releases the request
  a_irq_release: assert property (@(posedge clock) disable iff (reset)
    s_iack_taken |=> s_iack_answered) else $error("request not released");

  // the acknowledge cycle returns the identifier byte
  a_iack_word: assert property (@(posedge clock) disable iff (reset)
    iackHit |=> busRdata == {ONES8, $past(irqId_reg)}) else $error("wrong iack word");

  // an acknowledge for another level is left alone
  a_iack_level: assert property (@(posedge clock) disable iff (reset)
    iackCycle && busStrobe && iackLevel != levelSwitch && !busDtack |=> !busDtack) else $error("other level answered");

  // in upstream mode the external OR is ignored
  a_source_ext: assert property (@(posedge clock) disable iff (reset)
    !extMode && orRise && !stbRise && !trigValid_reg |=> !trigValid_reg) else $error("wrong source taken");

  // no trigger is taken while the gate bit is clear
  a_gate_off: assert property (@(posedge clock) disable iff (reset)
    !trigEn && !trigValid_reg && !softRst |=> !trigValid_reg) else $error("trigger while gated");

  // an accepted trigger raises the request when enabled
  a_irq_raise: assert property (@(posedge clock) disable iff (reset)
    accepted && irqEn && !softRst |=> irqReq) else $error("irq missing");

  // with interrupts off a trigger is only a status flag
  a_poll_only: assert property (@(posedge clock) disable iff (reset)
    accepted && !irqEn && !pending_reg && !testIrq |=> !irqReq) else $error("irq while disabled");

  // test interrupt with both bits set
  a_test_irq: assert property (@(posedge clock) disable iff (reset)
    testIrq && !softRst |=> irqReq) else $error("test irq missing");

  // test interrupt refused without the test bit
  a_test_blocked: assert property (@(posedge clock) disable iff (reset)
    wrTrig && busWdata[TRG_TESTIRQ] && !ctrl_reg[CSR_TEST] && !pending_reg && !accepted |=> !irqReq)
    else $error("test irq while off");

  // auto sample copies the inputs on an upstream trigger
  a_auto_sample: assert property (@(posedge clock) disable iff (reset)
    tsAccept && ctrl_reg[CSR_AUTO] |=> inPort_reg == $past({extData, extTrigger})) else $error("no auto sample");

  // no sampling of the input port in external mode
  a_ext_no_sample: assert property (@(posedge clock) disable iff (reset)
    extMode |=> $stable(inPort_reg)) else $error("sampled in external mode");

  // the reset bit clears controls, identifier, outputs and latch
  a_soft_reset: assert property (@(posedge clock) disable iff (reset)
    softRst |=> ctrl_reg == CTRL_RESET && irqId_reg == BYTE_RESET && generalOut == BYTE_RESET && !busy)
    else $error("soft reset");

  // level readback and zero bits of the control word
  a_csr_level: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_CSR |=> busRdata[CSR_LVL_LSB +: 3] == $past(levelSwitch) && busRdata[CSR_PEND-1 -: 3] == 3'h0)
    else $error("level readback");

  // pending flag reads back the request
  a_pending_flag: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_CSR |=> busRdata[CSR_PEND] == $past(pending_reg)) else $error("pending flag");

  // status flag reads back valid trigger data
  a_status_flag: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_CSR |=> busRdata[CSR_TSTAT] == $past(trigValid_reg)) else $error("status flag");

  // identifier upper byte reads as ones
  a_id_upper: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_IRQID |=> busRdata[DATA_W-1 -: 8] == ONES8) else $error("id upper byte");

  // upstream trigger word has ones above the code
  a_up_layout: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_TRIG && !extMode |=> busRdata[TRG_MODE-1 -: 4] == ONES4) else $error("upstream layout");

  // external trigger latches all twelve lines
  a_ext_latch: assert property (@(posedge clock) disable iff (reset)
    s_ext_taken |=> trigData_reg == $past({extData, extTrigger})) else $error("external latch");

  // mode bit and fixed one in the trigger word
  a_trig_mode: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_TRIG |=> busRdata[TRG_MODE] == $past(extMode) && busRdata[TRG_MODE+1])
    else $error("trigger word mode");

  // software acknowledge reaches the cable in upstream mode
  a_cable_ack: assert property (@(posedge clock) disable iff (reset)
    ackWrite && !extMode |=> $onehot(cableAck)) else $error("cable ack missing");

  // external acknowledge clears busy
  a_ext_ack: assert property (@(posedge clock) disable iff (reset)
    ackWrite && !accepted && extMode |=> !busy) else $error("busy not cleared");

  // output port upper byte reads as ones
  a_out_upper: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_OUTP |=> busRdata[DATA_W-1 -: 8] == ONES8) else $error("output upper byte");

  // input port reads all ones in external mode
  a_inp_ext: assert property (@(posedge clock) disable iff (reset)
    rd && offset == OFF_INP && extMode |=> busRdata == ONES16) else $error("input port ones");

  // in external mode, without an enabled input high nothing is taken
  a_unjumpered: assert property (@(posedge clock) disable iff (reset)
    extMode && !trigOr && !trigValid_reg |=> !busy) else $error("unjumpered trigger");

  // the cable acknowledge uses the assigned line only
  a_cable_line: assert property (@(posedge clock) disable iff (reset)
    ackOut_reg |-> cableAck[readoutNumber] && $onehot(cableAck)) else $error("wrong ack line");

  // latched data is held until acknowledge
  a_hold_off: assert property (@(posedge clock) disable iff (reset)
    busy && !ackWrite && !softRst |=> busy && $stable(trigData_reg)) else $error("data overwritten");

  // accept outputs rise after an external trigger
  a_accept_hold: assert property (@(posedge clock) disable iff (reset)
    s_ext_taken |=> s_ext_held) else $error("accept not raised");

  // accept stays up until acknowledge
  a_accept_stays: assert property (@(posedge clock) disable iff (reset)
    levelAccept && !ackWrite && !softRst && !wrCsr |=> levelAccept) else $error("accept dropped");

  // no trigger is taken while busy
  a_busy_refuse: assert property (@(posedge clock) disable iff (reset)
    busy |-> !accepted) else $error("trigger taken while busy");

  // upstream strobe captures the cable word and goes busy
  a_up_capture: assert property (@(posedge clock) disable iff (reset)
    s_up_taken |=> trigData_reg[7:0] == $past(cableWord) && busy) else $error("cable word not captured");
endmodule
`default_nettype wire

// File: rtl/trig_if_pkg.sv
// constants for the trigger interface register bank
package trig_if_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          BASE_W        = 12;
  localparam int          BASE_LSB      = 4;
  localparam logic [3:0]  OFF_CSR       = 4'h0;
  localparam logic [3:0]  OFF_IRQID     = 4'h2;
  localparam logic [3:0]  OFF_TRIG      = 4'h4;
  localparam logic [3:0]  OFF_OUTP      = 4'h6;
  localparam logic [3:0]  OFF_INP       = 4'h8;
  localparam logic [5:0]  AM_SHORT_SUP  = 6'h2D;
  localparam logic [5:0]  AM_SHORT_USR  = 6'h29;
  localparam int          CSR_EXT       = 0;
  localparam int          CSR_TEN       = 1;
  localparam int          CSR_IEN       = 2;
  localparam int          CSR_TEST      = 3;
  localparam int          CSR_AUTO      = 4;
  localparam int          CSR_RST       = 7;
  localparam int          CSR_LVL_LSB   = 8;
  localparam int          CSR_PEND      = 14;
  localparam int          CSR_TSTAT     = 15;
  localparam int          TRG_MODE      = 12;
  localparam int          TRG_TESTIRQ   = 14;
  localparam int          TRG_ACK       = 15;
  localparam logic [7:0]  ONES8         = 8'hFF;
  localparam logic [3:0]  ONES4         = 4'hF;
  localparam logic [15:0] ONES16        = 16'hFFFF;
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [11:0] WORD12_RESET  = 12'h000;
endpackage

// File: dv/bus_master_model.sv
// readout controller model: strobed short-address bus master
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic        clock,
  input  wire logic [15:0] busRdata,
  input  wire logic        busDtack,
  output var  logic [15:0] busAddr,
  output var  logic [5:0]  busAm,
  output var  logic        busStrobe,
  output var  logic        busWrite,
  output var  logic [15:0] busWdata,
  output var  logic        iackCycle
);
  initial {busAddr, busAm, busStrobe, busWrite, busWdata, iackCycle} = '0;
  // hold the request until dtack is sampled or 8 edges pass, then release and wait up to 8 edges for dtack low
  task automatic access(input logic [15:0] a, input logic [5:0] am, input logic we, input logic [15:0] wd,
                        input logic ia, output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'hFFFF;
    @(negedge clock);
    {busAddr, busAm, busWrite, busWdata, iackCycle, busStrobe} = {a, am, we, wd, ia, 1'b1};
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clock);
      ok = (busDtack === 1'b1);
      if (ok) rd = busRdata;
    end
    @(negedge clock);
    busStrobe = 1'b0;
    iackCycle = 1'b0;
    busWdata = ~busWdata; // released data and address lines never keep the last value
    busAddr = ~busAddr;
    for (n = 0; n < 8 && busDtack !== 1'b0; n++) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// File: dv/vme_trigger_interface_regs_tb.sv
// self-checking bench for the trigger interface register bank
`timescale 1ns/1ps
`default_nettype none
module vme_trigger_interface_regs_tb;
  import trig_if_pkg::*;
  typedef struct packed {logic [3:0] off; logic we; logic [15:0] wd; logic [15:0] ex;} row_type;
  localparam logic [11:0] BASE = 12'hA5C;
  logic        clock = 1'b0, reset = 1'b1, cableStrobe = 1'b0, ok;
  logic [3:0]  extTrigger = 4'h0;
  logic [7:0]  extData = 8'h00, cableWord = 8'h00, lastAck = 8'h00, cableAck, generalOut;
  logic [15:0] busAddr, busWdata, busRdata, rd;
  logic [5:0]  busAm;
  logic        busStrobe, busWrite, busDtack, iackCycle, irqReq, levelAccept, busy;
  logic [2:0]  irqLevel;
  logic [2:0]  iackLvl = 3'h5;
  int          badCount = 0, nCompared = 0;
  row_type     rows [9] = '{'{OFF_CSR, 1'b0, 16'h0, 16'h0500}, '{OFF_OUTP, 1'b1, 16'h0012, 16'h0},
    '{OFF_OUTP, 1'b0, 16'h0, 16'hFF12}, '{OFF_IRQID, 1'b1, 16'h00A7, 16'h0}, '{OFF_IRQID, 1'b0, 16'h0, 16'hFFA7},
    '{OFF_CSR, 1'b1, 16'h0003, 16'h0}, '{OFF_TRIG, 1'b0, 16'h0, 16'h3000}, '{OFF_INP, 1'b0, 16'h0, 16'hFFFF},
    '{4'hA, 1'b0, 16'h0, 16'hFFFF}};
  always #12.5 clock = ~clock;
  // remember any acknowledge line pulse
  always @(posedge clock) if (cableAck !== 8'h00) lastAck <= cableAck;
  vme_trigger_interface_regs i_vme_trigger_interface_regs (.clock(clock), .reset(reset), .busAddr(busAddr),
    .busAm(busAm), .busStrobe(busStrobe), .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata),
    .busDtack(busDtack), .iackCycle(iackCycle), .iackLevel(iackLvl), .irqReq(irqReq), .irqLevel(irqLevel),
    .baseSwitch(BASE), .levelSwitch(3'h5), .readoutNumber(3'h3), .trigEnableJumper(4'h5),
    .extTrigger(extTrigger), .extData(extData), .cableStrobe(cableStrobe), .cableWord(cableWord),
    .cableAck(cableAck), .generalOut(generalOut), .levelAccept(levelAccept), .busy(busy));
  bus_master_model i_bus_master_model (.clock(clock), .busRdata(busRdata), .busDtack(busDtack),
    .busAddr(busAddr), .busAm(busAm), .busStrobe(busStrobe), .busWrite(busWrite), .busWdata(busWdata),
    .iackCycle(iackCycle));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rw(input logic [3:0] off, input logic we, input logic [15:0] wd);
    i_bus_master_model.access({BASE, off}, AM_SHORT_SUP, we, wd, 1'b0, rd, ok);
  endtask
  task automatic iack;
    i_bus_master_model.access(16'h0000, AM_SHORT_SUP, 1'b0, 16'h0, 1'b1, rd, ok);
  endtask
  task automatic setExt(input logic [3:0] t, input logic [7:0] d);
    @(negedge clock);
    extTrigger = t;
    extData = d;
    repeat (3) @(negedge clock);
  endtask
  task automatic pulseCable(input logic [7:0] w);
    @(negedge clock);
    cableWord = w;
    cableStrobe = 1'b1;
    @(negedge clock);
    cableStrobe = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  task automatic tallyAndFinish;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    badCount++;
    tallyAndFinish();
  end
  // table rows, then refusals, trigger flows and the reset bit
  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    foreach (rows[i]) begin
      rw(rows[i].off, rows[i].we, rows[i].wd);
      if (!rows[i].we) chk("register row", rows[i].ex, rd);
    end
    chk("outputs", 16'h0012, 16'(generalOut));
    i_bus_master_model.access({BASE, OFF_CSR}, 6'h39, 1'b0, 16'h0, 1'b0, rd, ok);
    chk("dtack bad am", 16'h0, 16'(ok));
    i_bus_master_model.access({~BASE, OFF_CSR}, AM_SHORT_USR, 1'b0, 16'h0, 1'b0, rd, ok);
    chk("dtack bad base", 16'h0, 16'(ok));
    i_bus_master_model.access({BASE, OFF_CSR}, AM_SHORT_USR, 1'b0, 16'h0, 1'b0, rd, ok);
    chk("csr user am", 16'h0503, rd);
    rw(OFF_CSR, 1'b1, 16'h0007);
    setExt(4'hA, 8'h5A);
    chk("busy unjumpered", 16'h0, 16'(busy));
    setExt(4'hB, 8'h5A);
    chk("trigger pins", 16'h003D, 16'({busy, levelAccept, irqReq, irqLevel}));
    rw(OFF_CSR, 1'b0, 16'h0);
    chk("csr pending", 16'hC507, rd);
    setExt(4'h0, 8'h00);
    setExt(4'h1, 8'hFF);
    rw(OFF_TRIG, 1'b0, 16'h0);
    chk("trig ext", 16'h35AB, rd);
    iack();
    chk("iack id", 16'hFFA7, rd);
    chk("irq released", 16'h0, 16'(irqReq));
    rw(OFF_TRIG, 1'b1, 16'h8000);
    chk("ext ack", 16'h0, {6'h0, busy, levelAccept, lastAck});
    rw(OFF_CSR, 1'b1, 16'h0004);
    rw(OFF_TRIG, 1'b1, 16'h4000);
    chk("test irq off", 16'h0, 16'(irqReq));
    rw(OFF_CSR, 1'b1, 16'h000C);
    rw(OFF_TRIG, 1'b1, 16'h4000);
    chk("test irq on", 16'h1, 16'(irqReq));
    iackLvl = 3'h2;
    iack();
    chk("iack other level", 16'h1, {14'h0, ok, irqReq});
    iackLvl = 3'h5;
    iack();
    rw(OFF_CSR, 1'b1, 16'h0010);
    setExt(4'h6, 8'h3C);
    pulseCable(8'hC9);
    chk("gated", 16'h0, 16'(busy));
    rw(OFF_CSR, 1'b1, 16'h0012);
    pulseCable(8'hC9);
    rw(OFF_CSR, 1'b0, 16'h0);
    chk("csr up", 16'h8512, rd);
    rw(OFF_TRIG, 1'b0, 16'h0);
    chk("trig up", 16'h2FC9, rd);
    rw(OFF_INP, 1'b0, 16'h0);
    chk("inp auto", 16'hF3C6, rd);
    rw(OFF_TRIG, 1'b1, 16'h8000);
    chk("cable ack", 16'h0008, {7'h0, busy, lastAck});
    rw(OFF_CSR, 1'b1, 16'h0080);
    rw(OFF_CSR, 1'b0, 16'h0);
    chk("csr cleared", 16'h0500, rd);
    rw(OFF_IRQID, 1'b0, 16'h0);
    chk("id cleared", 16'hFF00, rd);
    chk("outputs cleared", 16'h0, 16'(generalOut));
    tallyAndFinish();
  end
endmodule
`default_nettype wire
